// >>> verilog/prc_pkg.sv
// Contract
// - bits 4:3 pick port A, B, C, D
// - bits 2:0 pick pin bit 0..7
// - same encoding everywhere; pins shareable
// - port read returns true pin level
// - invalid port for input gives zero
// - analog signals never routed
// - per-pin output select; direction keeps control
// - usart, serial port, generator override direction
// - locked: select writes ignored
// - lock change needs 0x55 then 0xAA
// - one-shot: clear once, set once; code refuses every clear after the set, so no clear takes effect
// - one-shot: set lock stays until reset
// - sleep leaves selections unchanged
// - only power-on reset restores defaults
// - input select default per peripheral, 7:5 zero
// - output code 00000 selects own latch
// - reserved or invalid output code gives zero
// - lock bit 0, resets zero
package prc_pkg;
    localparam int PRC_NUM_IN = 16;
    localparam int PRC_NUM_PIN = 32;
    localparam int PRC_AW = 8;
    // register map: inputs at 0x00.., pins at 0x20.., lock at 0x40
    localparam logic [7:0] PRC_IN_BASE = 8'h00;
    localparam logic [7:0] PRC_PIN_BASE = 8'h20;
    localparam logic [7:0] PRC_LOCK_OFS = 8'h40;
    localparam logic [7:0] PRC_PORT_OFS = 8'h41;
    localparam logic [7:0] PRC_KEY1 = 8'h55;
    localparam logic [7:0] PRC_KEY2 = 8'hAA;
    localparam int PRC_LOCK_BIT = 0;
    localparam logic [4:0] PRC_OUT_LATCH = 5'h00;
    // reserved output codes 00001, 00010, 10010, 10011 and 11xxx
    localparam logic [31:0] PRC_OUT_RSVD = 32'hFF0C_0006;
    localparam int PRC_NUM_OUT_SIG = 32;
    localparam int PRC_KEY_WINDOW = 3;
endpackage

// >>> verilog/prc_lock_ctl.sv
`timescale 1ns/1ns
// lock bit with unlock sequence and one-shot mode
module prc_lock_ctl
    import prc_pkg::*;
(
    input wire logic clk_i,
    input wire logic por_n_i,
    input wire logic lock_wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic one_shot_lock_config_i,
    output logic route_locked_bit_o
);
    typedef enum logic [1:0] {PRC_IDLE, PRC_GOT55, PRC_ARMED} prc_key_t;
    prc_key_t st_q;
    prc_key_t st_d;
    logic lock_q;
    logic cleared_q; // one-shot clear spent
    logic setdone_q; // one-shot set spent
    wire want_set = wdata_i[PRC_LOCK_BIT];
    // one-shot: a clear after the set is refused until power-on reset
    wire may_clr = !one_shot_lock_config_i || (!cleared_q && !setdone_q);
    wire may_set = !one_shot_lock_config_i || !setdone_q;
    wire apply = lock_wr_i && (st_q == PRC_ARMED);
    wire do_set = apply && want_set && may_set;
    wire do_clr = apply && !want_set && may_clr && lock_q;

    // key detector: any other lock write returns to idle
    always_comb begin
        st_d = st_q;
        if (lock_wr_i) begin
            case (st_q)
                PRC_IDLE: st_d = (wdata_i == PRC_KEY1) ? PRC_GOT55 : PRC_IDLE;
                PRC_GOT55: st_d = (wdata_i == PRC_KEY2) ? PRC_ARMED : PRC_IDLE;
                PRC_ARMED: st_d = PRC_IDLE;
                default: st_d = PRC_IDLE;
            endcase
        end
    end

    // state regs; only power-on reset clears the one-shot flags; lock also clears on a keyed write
    always_ff @(posedge clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            st_q <= PRC_IDLE;
            lock_q <= 1'b0;
            cleared_q <= 1'b0;
            setdone_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (do_set) lock_q <= 1'b1;
            else if (do_clr) lock_q <= 1'b0;
            if (do_clr) cleared_q <= 1'b1;
            if (do_set) setdone_q <= 1'b1;
        end
    end
    assign route_locked_bit_o = lock_q;

    sequence key_seq_s;
        lock_wr_i && wdata_i == PRC_KEY1 && st_q == PRC_IDLE
        ##1 !lock_wr_i ##1 lock_wr_i && wdata_i == PRC_KEY2;
    endsequence
    lock_needs_key_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        !lock_q && st_q != PRC_ARMED |=> !lock_q) else $error("lock set no key");
    key_arms_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        key_seq_s |=> st_q == PRC_ARMED) else $error("key not armed");
    oneshot_hold_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        one_shot_lock_config_i && lock_q && setdone_q |=> lock_q)
        else $error("one-shot lock cleared");
endmodule // prc_lock_ctl

// >>> verilog/prc_crossbar.sv
`timescale 1ns/1ns
// peripheral pin select crossbar
module prc_crossbar
    import prc_pkg::*;
#(
    parameter int NUM_IN = PRC_NUM_IN,
    parameter logic [4:0] IN_RST [NUM_IN] = '{default: 5'h00},
    parameter logic [3:0] IN_PORT_OK [NUM_IN] = '{default: 4'hF},
    parameter logic [31:0] OUT_SIG_OK [PRC_NUM_PIN] = '{default: 32'hFFFF_FFFF},
    parameter logic [31:0] OVR_CODES = 32'h0033_0F00
)(
    input wire logic clk_i,
    input wire logic por_n_i,
    input wire logic [PRC_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic one_shot_lock_config_i,
    input wire logic [PRC_NUM_PIN-1:0] pin_i,
    input wire logic [PRC_NUM_PIN-1:0] pin_output_latch_i,
    input wire logic [PRC_NUM_PIN-1:0] pin_direction_bit_i,
    input wire logic [PRC_NUM_OUT_SIG-1:0] periph_out_i,
    input wire logic [PRC_NUM_OUT_SIG-1:0] periph_oe_i,
    output logic [NUM_IN-1:0] periph_in_o,
    output logic [PRC_NUM_PIN-1:0] pin_o,
    output logic [PRC_NUM_PIN-1:0] pin_oe_o
);
    logic [PRC_NUM_PIN-1:0] pin_s1_q;
    logic [PRC_NUM_PIN-1:0] pin_s2_q; // synchronised pin levels
    logic [4:0] in_sel_q [NUM_IN];
    logic [4:0] out_sel_q [PRC_NUM_PIN];
    logic [NUM_IN-1:0] pin_in_d;
    logic [PRC_NUM_PIN-1:0] pin_d;
    logic [PRC_NUM_PIN-1:0] oe_d;
    logic [7:0] rdata_d;
    logic locked;

    // pin synchroniser: first stage read only by second
    always_ff @(posedge clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    wire lock_wr = wr_i && (addr_i == PRC_LOCK_OFS);
    wire in_hit = addr_i < (PRC_IN_BASE + 8'(NUM_IN));
    wire pin_hit = addr_i >= PRC_PIN_BASE && addr_i < (PRC_PIN_BASE + 8'(PRC_NUM_PIN));
    wire [7:0] in_idx = addr_i - PRC_IN_BASE;
    wire [7:0] pin_idx = addr_i - PRC_PIN_BASE;
    wire sel_wr_ok = wr_i && !locked;

    prc_lock_ctl u_lock (
        .clk_i(clk_i),
        .por_n_i(por_n_i),
        .lock_wr_i(lock_wr),
        .wdata_i(wdata_i),
        .one_shot_lock_config_i(one_shot_lock_config_i),
        .route_locked_bit_o(locked)
    );

    // input selects: one mux per peripheral input, same encoding
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            wire [1:0] port_sel = in_sel_q[gi][4:3];
            wire [2:0] bit_sel = in_sel_q[gi][2:0];
            wire [4:0] flat = {port_sel, bit_sel};
            // unsupported port feeds a zero
            assign pin_in_d[gi] = IN_PORT_OK[gi][port_sel] ? pin_s2_q[flat] : 1'b0;
            // power-on reset only; sleep has no path here
            always_ff @(posedge clk_i or negedge por_n_i) begin
                if (!por_n_i) in_sel_q[gi] <= IN_RST[gi];
                else if (sel_wr_ok && in_hit && in_idx == 8'(gi)) in_sel_q[gi] <= wdata_i[4:0];
            end
        end
    endgenerate

    // output selects and per-pin drive
    genvar gp;
    generate
        for (gp = 0; gp < PRC_NUM_PIN; gp++) begin : g_pin
            wire [4:0] code = out_sel_q[gp];
            wire is_latch = code == PRC_OUT_LATCH;
            wire valid = OUT_SIG_OK[gp][code] && !PRC_OUT_RSVD[code];
            wire ovr = OVR_CODES[code] && valid && periph_oe_i[code];
            // reserved or unlisted codes drive zero
            assign pin_d[gp] = is_latch ? pin_output_latch_i[gp]
                             : (valid ? periph_out_i[code] : 1'b0);
            assign oe_d[gp] = OVR_CODES[code] && valid ? ovr : !pin_direction_bit_i[gp];
            always_ff @(posedge clk_i or negedge por_n_i) begin
                if (!por_n_i) out_sel_q[gp] <= PRC_OUT_LATCH;
                else if (sel_wr_ok && pin_hit && pin_idx == 8'(gp)) out_sel_q[gp] <= wdata_i[4:0];
            end
        end
    endgenerate

    // read mux; upper bits read zero, port read shows real pins
    always_comb begin
        rdata_d = 8'h00;
        if (in_hit) rdata_d = {3'b000, in_sel_q[in_idx[$clog2(NUM_IN)-1:0]]};
        else if (pin_hit) rdata_d = {3'b000, out_sel_q[pin_idx[4:0]]};
        else if (addr_i == PRC_LOCK_OFS) rdata_d = {7'h00, locked};
        else if (addr_i >= PRC_PORT_OFS && addr_i < PRC_PORT_OFS + 8'h04)
            rdata_d = pin_s2_q[8*(addr_i-PRC_PORT_OFS) +: 8];
    end

    // outputs registered; analog paths bypass this block entirely
    always_ff @(posedge clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            rdata_o <= 8'h00;
            periph_in_o <= '0;
            pin_o <= '0;
            pin_oe_o <= '0;
        end else begin
            rdata_o <= rd_i ? rdata_d : 8'h00;
            periph_in_o <= pin_in_d;
            pin_o <= pin_d;
            pin_oe_o <= oe_d;
        end
    end

    locked_hold_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        locked && wr_i |=> $stable(in_sel_q[0]) && $stable(out_sel_q[0]))
        else $error("select changed while locked");
    latch_route_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        out_sel_q[0] == PRC_OUT_LATCH |=> pin_o[0] == $past(pin_output_latch_i[0]))
        else $error("latch not routed");
    bad_port_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        !IN_PORT_OK[0][in_sel_q[0][4:3]] |=> !periph_in_o[0])
        else $error("invalid port not zero");
    in_route_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        IN_PORT_OK[0][in_sel_q[0][4:3]] |=> periph_in_o[0] == $past(pin_s2_q[in_sel_q[0]]))
        else $error("input mux wrong");
    rd_next_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
        rd_i && addr_i == PRC_LOCK_OFS |=> rdata_o == {7'h00, $past(locked)})
        else $error("lock read wrong");
endmodule // prc_crossbar

// >>> tb/prc_pin_model.sv
`timescale 1ns/1ns
// far side: pads of the port pins, driven by the device or by the board
module prc_pin_model (
    input wire logic [31:0] ext_i, // board level on undriven pins
    input wire logic [31:0] pin_val_i, // device output value
    input wire logic [31:0] pin_en_i, // device output enable
    output logic [31:0] pad_o // resolved pad level back to the device
);
    // a driven pad shows the device value, so a shared pin loops back
    assign pad_o = (pin_en_i & pin_val_i) | (~pin_en_i & ext_i);
endmodule // prc_pin_model

// >>> tb/prc_crossbar_bench.sv
`timescale 1ns/1ns
// register, routing and lock checks through the register port
module prc_crossbar_bench;
    import prc_pkg::*;
    logic clk_i = 1'b0;
    logic por_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic one_shot = 1'b0;
    logic [31:0] ext = 32'h0000_0000;
    logic [31:0] latch = 32'h0000_0000;
    logic [31:0] dir = 32'hFFFF_FFFF;
    logic [31:0] p_out = 32'h0000_0000;
    logic [31:0] p_oe = 32'h0000_0000;
    logic [7:0] rdata_o;
    logic [15:0] periph_in_o;
    logic [31:0] pin_o, pin_oe_o, pad;
    int n_fail = 0;
    int n_tests = 0;
    always #5 clk_i = ~clk_i;
    prc_pin_model board (.ext_i(ext), .pin_val_i(pin_o), .pin_en_i(pin_oe_o), .pad_o(pad));
    // input 3 may only use port A, to see refusal of other ports
    prc_crossbar #(.IN_PORT_OK('{3: 4'h1, default: 4'hF})) dut (
        .clk_i(clk_i), .por_n_i(por_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .one_shot_lock_config_i(one_shot),
        .pin_i(pad), .pin_output_latch_i(latch), .pin_direction_bit_i(dir),
        .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(periph_in_o),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one write cycle, strobe dropped on the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(what, {24'h0, rdata_o}, {24'h0, exp});
    endtask
    // pin levels need the synchroniser plus output stage to settle
    task automatic drive(input logic [31:0] v);
        @(posedge clk_i);
        ext <= v;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic lock_seq(input logic [7:0] v);
        wr(PRC_LOCK_OFS, PRC_KEY1);
        wr(PRC_LOCK_OFS, PRC_KEY2);
        wr(PRC_LOCK_OFS, v);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog, well above the roughly 120 cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clk_i);
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        por_n_i <= 1'b1;
        rd(PRC_IN_BASE, 8'h00, "input select reset");
        rd(PRC_LOCK_OFS, 8'h00, "lock reset");
        rd(PRC_PIN_BASE, 8'h00, "output select reset");
        wr(PRC_IN_BASE, 8'hEB);
        rd(PRC_IN_BASE, 8'h0B, "input select upper bits");
        wr(PRC_IN_BASE + 8'h01, 8'h0B);
        // every port code with bit 5
        for (int p = 0; p < 4; p++) begin
            wr(PRC_IN_BASE + 8'h02, {3'b000, 2'(p), 3'b101});
            drive(32'h0000_0001 << (p * 8 + 5));
            chk("port bit select", {31'h0, periph_in_o[2]}, 32'h1);
        end
        drive(32'h0000_0800);
        chk("shared pin", {30'h0, periph_in_o[1:0]}, 32'h3);
        rd(PRC_PORT_OFS + 8'h01, 8'h08, "routed port read");
        wr(PRC_IN_BASE + 8'h03, 8'h08);
        drive(32'h0000_0100);
        chk("invalid port", {31'h0, periph_in_o[3]}, 32'h0);
        @(posedge clk_i);
        latch <= 32'h0000_0001;
        dir <= 32'hFFFF_FFF0;
        p_out <= 32'hFFFF_FFFF;
        wr(PRC_PIN_BASE + 8'h01, 8'h18);
        wr(PRC_PIN_BASE + 8'h02, 8'h10);
        wr(PRC_PIN_BASE + 8'h03, 8'h0C);
        drive(32'h0000_0000);
        chk("latch out", {30'h0, pin_oe_o[0], pin_o[0]}, 32'h3);
        chk("reserved code", {31'h0, pin_o[1]}, 32'h0);
        chk("override enable", {31'h0, pin_oe_o[2]}, 32'h0);
        chk("peripheral out", {30'h0, pin_oe_o[3], pin_o[3]}, 32'h3);
        lock_seq(8'h01);
        rd(PRC_LOCK_OFS, 8'h01, "lock set");
        wr(PRC_IN_BASE, 8'h11);
        rd(PRC_IN_BASE, 8'h0B, "locked select");
        // a stray write between the keys must abort the sequence
        wr(PRC_LOCK_OFS, PRC_KEY1);
        wr(PRC_LOCK_OFS, 8'h00);
        wr(PRC_LOCK_OFS, PRC_KEY2);
        wr(PRC_LOCK_OFS, 8'h00);
        rd(PRC_LOCK_OFS, 8'h01, "broken key");
        lock_seq(8'h00);
        rd(PRC_LOCK_OFS, 8'h00, "lock cleared");
        // fresh power-on reset in one-shot mode
        @(posedge clk_i);
        one_shot <= 1'b1;
        por_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        por_n_i <= 1'b1;
        rd(PRC_IN_BASE, 8'h00, "power-on default");
        lock_seq(8'h01);
        lock_seq(8'h00);
        rd(PRC_LOCK_OFS, 8'h01, "one-shot hold");
        finish_test;
    end
endmodule // prc_crossbar_bench
